// >>> cafc_pkg.sv
// package: register map, field layout and reset values of the filter control block
package cafc_pkg;
  localparam int CAFC_NUM_FILTERS = 4;
  localparam int CAFC_FIRST_FILTER = 20;
  localparam int CAFC_ID_W = 11;
  localparam int CAFC_NUM_MASKS = 4;
  localparam logic [11:0] CAFC_CTRL_OFFSET = 12'h000;
  localparam logic [11:0] CAFC_MASK0_OFFSET = 12'h004;
  localparam logic [11:0] CAFC_FVAL0_OFFSET = 12'h014;
  localparam logic [11:0] CAFC_MATCH_OFFSET = 12'h024;
  localparam int CAFC_EN_POS = 7;
  localparam int CAFC_MSEL_HI = 6;
  localparam int CAFC_MSEL_LO = 5;
  localparam int CAFC_FSEL_HI = 4;
  localparam int CAFC_FSEL_LO = 0;
  localparam logic [31:0] CAFC_CTRL_RESET = 32'h0000_0000;
  localparam logic [10:0] CAFC_WORD_RESET = 11'h000;
endpackage : cafc_pkg

// >>> cafc_filter_match.sv
// one acceptance filter compare stage
`timescale 1ns/1ps
module cafc_filter_match
  import cafc_pkg::*;
#(
  parameter int ID_W = CAFC_ID_W
) (
  input wire logic enable,
  input wire logic [ID_W-1:0] rx_id,
  input wire logic [ID_W-1:0] filter_value,
  input wire logic [ID_W-1:0] mask_value,
  output logic hit
);
  // only mask-marked bits are compared; disabled filter never hits
  always_comb begin
    hit = enable && (((rx_id ^ filter_value) & mask_value) == '0);
  end
endmodule : cafc_filter_match

// >>> cafc_filter_ctrl.sv
// apb register block and acceptance routing for filters 20 to 23
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module cafc_filter_ctrl
  import cafc_pkg::*;
#(
  parameter int ID_W = CAFC_ID_W
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic [ID_W-1:0] rx_id,
  output logic accept_valid,
  output logic [4:0] accept_fifo,
  output logic [1:0] accept_filter
);
  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [31:0] ctrl_q, ctrl_d;
  logic [ID_W-1:0] mask_q [CAFC_NUM_MASKS];
  logic [ID_W-1:0] mask_d [CAFC_NUM_MASKS];
  logic [ID_W-1:0] fval_q [CAFC_NUM_FILTERS];
  logic [ID_W-1:0] fval_d [CAFC_NUM_FILTERS];
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic acc_v_q, acc_v_d;
  logic [4:0] acc_f_q, acc_f_d;
  logic [1:0] acc_n_q, acc_n_d;
  logic [CAFC_NUM_FILTERS-1:0] hit;
  logic setup, access, wr, hit_addr;

  assign setup = psel && !penable;
  // writes commit only at the access edge, where the master sees pready high
  assign access = psel && penable && pready_q;
  assign wr = access && pwrite;

  // ------------------------------------------------------------
  // per-filter compare
  // ------------------------------------------------------------
  for (genvar g = 0; g < CAFC_NUM_FILTERS; g++) begin : g_flt
    cafc_filter_match #(.ID_W(ID_W)) u_match (
      .enable(ctrl_q[8*g+CAFC_EN_POS]),
      .rx_id(rx_id),
      .filter_value(fval_q[g]),
      .mask_value(mask_q[ctrl_q[8*g+CAFC_MSEL_LO +: 2]]),
      .hit(hit[g])
    );
  end

  // ------------------------------------------------------------
  // bus and register next state
  // ------------------------------------------------------------
  // answer in access phase one cycle after setup; pready always high there
  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    fval_d = fval_q;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    pready_d = setup;
    hit_addr = 1'b0;
    if (paddr == CAFC_CTRL_OFFSET || paddr == CAFC_MATCH_OFFSET) begin
      hit_addr = 1'b1;
    end
    for (int i = 0; i < CAFC_NUM_MASKS; i++) begin
      if (paddr == CAFC_MASK0_OFFSET + 12'(4*i)) begin
        hit_addr = 1'b1;
      end
    end
    for (int i = 0; i < CAFC_NUM_FILTERS; i++) begin
      if (paddr == CAFC_FVAL0_OFFSET + 12'(4*i)) begin
        hit_addr = 1'b1;
      end
    end
    if (setup) begin
      pslverr_d = !hit_addr;
      prdata_d = 32'h0000_0000;
    end
    if (wr && paddr == CAFC_CTRL_OFFSET) begin
      for (int i = 0; i < CAFC_NUM_FILTERS; i++) begin
        // bits below enable locked while enabled; clearing enable is the only legal write
        if (pstrb[i]) begin
          if (!ctrl_q[8*i+CAFC_EN_POS]) begin
            ctrl_d[8*i +: 8] = pwdata[8*i +: 8];
          end else begin
            ctrl_d[8*i+CAFC_EN_POS] = pwdata[8*i+CAFC_EN_POS];
          end
        end
      end
    end
    for (int i = 0; i < CAFC_NUM_MASKS; i++) begin
      if (wr && paddr == CAFC_MASK0_OFFSET + 12'(4*i)) begin
        mask_d[i] = pwdata[ID_W-1:0];
      end
    end
    for (int i = 0; i < CAFC_NUM_FILTERS; i++) begin
      // stored value belongs to filter config, locked likewise
      if (wr && paddr == CAFC_FVAL0_OFFSET + 12'(4*i) && !ctrl_q[8*i+CAFC_EN_POS]) begin
        fval_d[i] = pwdata[ID_W-1:0];
      end
    end
    if (setup && !pwrite) begin
      if (paddr == CAFC_CTRL_OFFSET) begin
        prdata_d = ctrl_q;
      end
      if (paddr == CAFC_MATCH_OFFSET) begin
        prdata_d = {22'h0, acc_v_q, acc_n_q, acc_f_q, 2'h0};
      end
      for (int i = 0; i < CAFC_NUM_MASKS; i++) begin
        if (paddr == CAFC_MASK0_OFFSET + 12'(4*i)) begin
          prdata_d = 32'(mask_q[i]);
        end
      end
      for (int i = 0; i < CAFC_NUM_FILTERS; i++) begin
        if (paddr == CAFC_FVAL0_OFFSET + 12'(4*i)) begin
          prdata_d = 32'(fval_q[i]);
        end
      end
    end
  end

  // ------------------------------------------------------------
  // acceptance routing, lowest filter number wins
  // ------------------------------------------------------------
  always_comb begin
    acc_v_d = 1'b0;
    acc_f_d = acc_f_q;
    acc_n_d = acc_n_q;
    if (rx_valid) begin
      for (int i = CAFC_NUM_FILTERS - 1; i >= 0; i--) begin
        if (hit[i]) begin
          acc_v_d = 1'b1;
          acc_f_d = ctrl_q[8*i+CAFC_FSEL_LO +: 5];
          acc_n_d = 2'(i);
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CAFC_CTRL_RESET;
      for (int i = 0; i < CAFC_NUM_MASKS; i++) begin
        mask_q[i] <= CAFC_WORD_RESET;
      end
      for (int i = 0; i < CAFC_NUM_FILTERS; i++) begin
        fval_q[i] <= CAFC_WORD_RESET;
      end
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      acc_v_q <= 1'b0;
      acc_f_q <= 5'h00;
      acc_n_q <= 2'h0;
    end else begin
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
      fval_q <= fval_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      acc_v_q <= acc_v_d;
      acc_f_q <= acc_f_d;
      acc_n_q <= acc_n_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign accept_valid = acc_v_q;
  assign accept_fifo = acc_f_q;
  assign accept_filter = acc_n_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_reset_zero;
    @(posedge ref_clk) $rose(rst_b) |-> ctrl_q == CAFC_CTRL_RESET;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("ctrl not zero after reset");

  property p_lock;
    @(posedge ref_clk) disable iff (!rst_b)
      ctrl_q[31] |=> ctrl_q[30:24] == $past(ctrl_q[30:24]);
  endproperty
  a_lock: assert property (p_lock) else $error("locked filter 23 fields changed");

  property p_lock_low;
    @(posedge ref_clk) disable iff (!rst_b)
      ctrl_q[7] |=> ctrl_q[6:0] == $past(ctrl_q[6:0]);
  endproperty
  a_lock_low: assert property (p_lock_low) else $error("locked filter 20 fields changed");

  property p_write_byte;
    @(posedge ref_clk) disable iff (!rst_b)
      wr && paddr == CAFC_CTRL_OFFSET && pstrb[0] && !ctrl_q[7]
      |=> ctrl_q[7:0] == $past(pwdata[7:0]);
  endproperty
  a_write_byte: assert property (p_write_byte) else $error("open filter byte not written");

  property p_dest;
    @(posedge ref_clk) disable iff (!rst_b)
      rx_valid && hit[0] |=> accept_valid && accept_fifo == $past(ctrl_q[4:0]);
  endproperty
  a_dest: assert property (p_dest) else $error("wrong destination fifo");

  property p_disabled;
    @(posedge ref_clk) disable iff (!rst_b)
      rx_valid && !ctrl_q[31] && !ctrl_q[23] && !ctrl_q[15] && !ctrl_q[7] |=> !accept_valid;
  endproperty
  a_disabled: assert property (p_disabled) else $error("accept with all filters off");

  property p_mask;
    @(posedge ref_clk) disable iff (!rst_b)
      rx_valid && ctrl_q[7] && ((rx_id ^ fval_q[0]) & mask_q[ctrl_q[6:5]]) == '0
      |=> accept_valid && accept_filter == 2'h0;
  endproperty
  a_mask: assert property (p_mask) else $error("masked compare missed");

  property p_answer;
    @(posedge ref_clk) disable iff (!rst_b) setup |=> pready ##1 !pready;
  endproperty
  a_answer: assert property (p_answer) else $error("apb answer timing");

  property p_lock_mid;
    @(posedge ref_clk) disable iff (!rst_b)
      ctrl_q[23] |=> ctrl_q[22:16] == $past(ctrl_q[22:16]);
  endproperty
  a_lock_mid: assert property (p_lock_mid) else $error("locked filter 22 fields changed");

  property p_lock_21;
    @(posedge ref_clk) disable iff (!rst_b)
      ctrl_q[15] |=> ctrl_q[14:8] == $past(ctrl_q[14:8]);
  endproperty
  a_lock_21: assert property (p_lock_21) else $error("locked filter 21 fields changed");

  property p_fval_lock;
    @(posedge ref_clk) disable iff (!rst_b)
      ctrl_q[31] |=> fval_q[3] == $past(fval_q[3]);
  endproperty
  a_fval_lock: assert property (p_fval_lock) else $error("locked filter 23 value changed");

  property p_write_top;
    @(posedge ref_clk) disable iff (!rst_b)
      wr && paddr == CAFC_CTRL_OFFSET && pstrb[3] && !ctrl_q[31]
      |=> ctrl_q[31:24] == $past(pwdata[31:24]);
  endproperty
  a_write_top: assert property (p_write_top) else $error("open filter 23 byte lost");

  property p_en_clear;
    @(posedge ref_clk) disable iff (!rst_b)
      wr && paddr == CAFC_CTRL_OFFSET && pstrb[3] && ctrl_q[31]
      |=> ctrl_q[31] == $past(pwdata[31]);
  endproperty
  a_en_clear: assert property (p_en_clear) else $error("enable not writable");

  property p_dest_hi;
    @(posedge ref_clk) disable iff (!rst_b)
      rx_valid && hit == 4'h8
      |=> accept_valid && accept_filter == 2'h3 && accept_fifo == $past(ctrl_q[28:24]);
  endproperty
  a_dest_hi: assert property (p_dest_hi) else $error("wrong filter 23 route");

  property p_no_hit;
    @(posedge ref_clk) disable iff (!rst_b)
      rx_valid && hit == 4'h0 |=> !accept_valid;
  endproperty
  a_no_hit: assert property (p_no_hit) else $error("accept without a hit");

  property p_mask_two;
    @(posedge ref_clk) disable iff (!rst_b)
      rx_valid && ctrl_q[23] && ctrl_q[22:21] == 2'h2 && hit[1:0] == 2'h0
      && ((rx_id ^ fval_q[2]) & mask_q[2]) == '0
      |=> accept_valid && accept_filter == 2'h2;
  endproperty
  a_mask_two: assert property (p_mask_two) else $error("mask 2 compare missed");

  property p_mask_three;
    @(posedge ref_clk) disable iff (!rst_b)
      rx_valid && ctrl_q[31] && ctrl_q[30:29] == 2'h3 && hit[2:0] == 3'h0
      && ((rx_id ^ fval_q[3]) & mask_q[3]) == '0
      |=> accept_valid && accept_filter == 2'h3;
  endproperty
  a_mask_three: assert property (p_mask_three) else $error("mask 3 compare missed");

  property p_slverr;
    @(posedge ref_clk) disable iff (!rst_b)
      setup && !hit_addr |=> pslverr && pready;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped access not flagged");

  property p_idle;
    @(posedge ref_clk) disable iff (!rst_b)
      !rx_valid |=> !accept_valid;
  endproperty
  a_idle: assert property (p_idle) else $error("accept without a frame");
endmodule : cafc_filter_ctrl

// >>> cafc_rx_model.sv
// receive path model: presents received identifiers to the filters
`timescale 1ns/1ps
module cafc_rx_model
  import cafc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic send,
  input wire logic [CAFC_ID_W-1:0] id_in,
  output logic rx_valid,
  output logic [CAFC_ID_W-1:0] rx_id
);
  // ---------------------------
  // one-cycle identifier pulse
  // ---------------------------
  // id toggles when not valid so a stale value is never mistaken for a frame
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_valid <= 1'b0;
      rx_id <= 11'h000;
    end else begin
      rx_valid <= send;
      rx_id <= send ? id_in : ~rx_id;
    end
  end
endmodule : cafc_rx_model

// >>> cafc_filter_ctrl_bench.sv
// self-checking bench for the filter control block
`timescale 1ns/1ps
module cafc_filter_ctrl_bench
  import cafc_pkg::*;
;
  // ---------------------------
  // signals and instances
  // ---------------------------
  logic ref_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic send = 1'b0, pready, pslverr, rx_valid, accept_valid, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic [10:0] rx_id, id_in = 11'h000;
  logic [4:0] accept_fifo;
  logic [1:0] accept_filter;
  int mismatches = 0, checks_done = 0;
  cafc_filter_ctrl cafc_filter_ctrl_i (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .rx_valid, .rx_id, .accept_valid,
    .accept_fifo, .accept_filter);
  cafc_rx_model cafc_rx_model_i (.ref_clk, .rst_b, .send, .id_in, .rx_valid, .rx_id);
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  // ---------------------------
  // shared tasks
  // ---------------------------
  task wrap_up;
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // master holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t no pready", $time);
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rx(input logic [10:0] id, input logic v, input logic [4:0] f,
                    input logic [1:0] n);
    @(posedge ref_clk);
    send <= 1'b1;
    id_in <= id;
    @(posedge ref_clk);
    send <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk({31'h0, accept_valid}, {31'h0, v});
    if (v) chk({25'h0, accept_filter, accept_fifo}, {25'h0, n, f});
  endtask : rx
  // ---------------------------
  // scenarios
  // ---------------------------
  task t_fields;
    apb(1'b0, CAFC_CTRL_OFFSET, 32'h0);
    chk(rd, CAFC_CTRL_RESET);
    apb(1'b1, CAFC_CTRL_OFFSET, 32'h7F5E_2100);
    apb(1'b0, CAFC_CTRL_OFFSET, 32'h0);
    chk(rd, 32'h7F5E_2100);
  endtask : t_fields
  // mask 1 keeps only the top three id bits; mask 0 at reset accepts all
  task t_accept;
    apb(1'b1, 12'h008, 32'h0000_0700);
    apb(1'b1, CAFC_FVAL0_OFFSET, 32'h0000_0123);
    apb(1'b1, CAFC_CTRL_OFFSET, 32'h0000_9FA5);
    rx(11'h1FF, 1'b1, 5'h05, 2'h0);
    rx(11'h223, 1'b1, 5'h1F, 2'h1);
  endtask : t_accept
  task t_lock;
    apb(1'b1, CAFC_CTRL_OFFSET, 32'h0000_9F7F);
    apb(1'b0, CAFC_CTRL_OFFSET, 32'h0);
    chk(rd, 32'h0000_9F25);
    apb(1'b1, CAFC_CTRL_OFFSET, 32'h0000_9F1F);
    apb(1'b0, CAFC_CTRL_OFFSET, 32'h0);
    chk(rd, 32'h0000_9F1F);
    rx(11'h1FF, 1'b1, 5'h1F, 2'h1);
    apb(1'b1, CAFC_CTRL_OFFSET, 32'h0000_1F1F);
    rx(11'h1FF, 1'b0, 5'h00, 2'h0);
  endtask : t_lock
  task t_unmapped;
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, er}, 32'h1);
  endtask : t_unmapped
  // masks 2 and 3 on filters 22 and 23; mask 3 makes every id bit count
  task t_high;
    apb(1'b1, 12'h00C, 32'h0000_0001);
    apb(1'b1, 12'h010, 32'h0000_07FF);
    apb(1'b1, 12'h01C, 32'h0000_0001);
    apb(1'b1, 12'h020, 32'h0000_0554);
    apb(1'b1, CAFC_CTRL_OFFSET, 32'hFEC3_0000);
    rx(11'h554, 1'b1, 5'h1E, 2'h3);
    rx(11'h555, 1'b1, 5'h03, 2'h2);
    rx(11'h556, 1'b0, 5'h00, 2'h0);
    apb(1'b0, CAFC_MATCH_OFFSET, 32'h0);
    chk(rd, 32'h0000_010C);
    chk({31'h0, er}, 32'h0);
    apb(1'b1, 12'h020, 32'h0000_0000);
    apb(1'b0, 12'h020, 32'h0);
    chk(rd, 32'h0000_0554);
    apb(1'b1, CAFC_CTRL_OFFSET, 32'h7C00_0000);
    apb(1'b0, CAFC_CTRL_OFFSET, 32'h0);
    chk(rd, 32'h7E43_0000);
    rx(11'h554, 1'b0, 5'h00, 2'h0);
  endtask : t_high
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_fields();
    t_accept();
    t_lock();
    t_unmapped();
    t_high();
    wrap_up();
  end
endmodule : cafc_filter_ctrl_bench
